// ===== src/radio_cfg.svh
// shared constants of the radio state controller and its host
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH

// --------------------
// timing
// --------------------
`define CLK_MHZ 200
`define HW_RESET_WAIT_US 1000

// --------------------
// command byte codes
// --------------------
`define CMD_OFF 8'hB0
`define CMD_ON 8'hB1
`define CMD_RX 8'hB2
`define CMD_TX 8'hB5
`define CMD_SLEEP 8'hBA
`define CMD_CONFIG 8'hBB
`define CMD_SYNC 8'hA2
`define HARDWARE_RESET_COMMAND 8'hC8
`define CMD_AES 8'hD0
`define CMD_IMGCAL 8'hBD
`define CMD_RS 8'hD1

// --------------------
// device memory map
// --------------------
`define ADDR_CHAN_HI 12'h109
`define ADDR_CHAN_MID 12'h10A
`define ADDR_CHAN_LO 12'h10B
`define ADDR_OPCTRL 12'h11A
`define CFG_BASE 12'h100
`define CFG_LAST 12'h13F
`define CFG_BYTES 7'h40

// operating_control bit positions
`define CTL_CAL_BIT 0
`define CTL_RX2TX_BIT 1
`define CTL_TX2RX_BIT 2
`define CTL_IRQ_BIT 3

// sleep variants
`define SLEEP_TIMED 2'h0
`define SLEEP_DEEP2 2'h2

// general-purpose pin roles
`define GP_SERIAL_PIN 1
`define GP_IRQ_PIN 3

// --------------------
// host register map (byte offsets) and fields
// --------------------
`define REG_CTRL 4'h0
`define REG_CMD 4'h4
`define REG_MEM 4'h8
`define REG_STATUS 4'hC
`define CTRL_CS_BIT 0
`define CTRL_WAKE_BIT 1
`define MEM_ADDR_LSB 16
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ===== src/radio_pkg.sv
// types shared by the radio state controller and its host
package radio_pkg;

   typedef enum logic [2:0] {
      sleep_state,
      off_state,
      on_state,
      transmit_state,
      receive_state
   } radio_state_t;

   typedef struct packed {
      radio_state_t st;
      logic [1:0] sleep_mode;
      logic awake;
      logic por;
      logic cmd_ready;
      logic [23:0] chan;
      logic [7:0] ctrl;
      logic [23:0] chan_applied;
      logic pa_en;
      logic cal;
      logic cfg_apply;
      logic irq;
      logic [2:0] fw_ack;
      logic tx_serial;
      logic mem_clear;
      logic [3:0] gp_out;
      logic [3:0] gp_oe_n;
   } dev_state_t;

endpackage

// ===== src/radio_link_if.sv
// serial control link between host and radio state controller
`timescale 1ns/1ps
interface radio_link_if;
   logic cs_n;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic mem_valid;
   logic [11:0] mem_addr;
   logic [7:0] mem_data;
   logic awake;
   logic cmd_ready;
   logic por;
   radio_pkg::radio_state_t state;

   modport dev (
      input cs_n, cmd_valid, cmd_code, mem_valid, mem_addr, mem_data,
      output awake, cmd_ready, por, state
   );
   modport host (
      output cs_n, cmd_valid, cmd_code, mem_valid, mem_addr, mem_data,
      input awake, cmd_ready, por, state
   );
endinterface

// ===== src/radio_state_controller.sv
// device end: radio state controller
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "radio_cfg.svh"

// What this block does
// R1: five states, moved by one-byte commands
// R2: sleep accepted only from off or on
// R3: wake on chip select low or timer
// R4: host arms wake timer before sleep
// R5: hardware reset enters deep sleep two
// R6: sleep: pin three low, others released
// R7: off state gives full memory access
// R8: host validates configuration before leaving off
// R9: off to on calibrates when enabled
// R10: transmit and receive use channel setting
// R11: packet sent: amplifier off, back on
// R12: sport transmit sends serial pin one
// R13: host ends sport transmit with on
// R14: packet received: back to on
// R15: sport mode suppresses end-of-frame exits
// R16: turnaround only when its bit set
// R17: firmware commands need loaded module
// R18: power-up: por, off, memories cleared
// R19: host power-up configuration sequence
// R20: hardware reset, wait, wake with por
// R21: chip-select wake from timed sleep keeps configuration, no por
// R22: configure applies all but channel
// R23: illegal transition commands are ignored
module radio_state_controller #(
   parameter int GP_COUNT = 4
) (
   input wire logic aclk, // 200 MHz clock
   input wire logic aresetn, // power-on reset, low
   radio_link_if.dev lk, // link to host
   input wire logic wake_expire, // wakeup controller expired
   input wire logic packet_sent, // stored packet finished
   input wire logic packet_received, // valid packet received
   input wire logic sport_mode, // synchronous serial mode
   input wire logic [2:0] fw_loaded, // aes, imgcal, rs loaded
   input wire logic [3:0] gp_in, // gp pin levels
   output logic [3:0] gp_out, // gp pin drive values
   output logic [3:0] gp_oe_n, // gp drive enables, low
   output radio_pkg::radio_state_t state, // current state
   output logic pa_enable, // power amplifier on
   output logic filter_cal, // calibration start pulse
   output logic config_apply, // configure pulse
   output logic [23:0] applied_channel, // channel in use
   output logic [7:0] operating_control, // control byte
   output logic tx_serial, // sport transmit data
   output logic packet_irq, // end-of-frame pulse
   output logic [2:0] fw_cmd_ack, // firmware command pulses
   output logic memory_clear // por memory clear pulse
);

   initial
   begin
      if (GP_COUNT != 4)
         $error("GP_COUNT must be 4");
   end

   radio_pkg::dev_state_t s;
   radio_pkg::dev_state_t next_s;
   radio_pkg::dev_state_t reset_s;
   logic accept;
   logic writable;
   logic ctrl_cal;
   logic ctrl_rx2tx;
   logic ctrl_tx2rx;
   logic ctrl_irq;

   assign ctrl_cal = s.ctrl[`CTL_CAL_BIT];
   assign ctrl_rx2tx = s.ctrl[`CTL_RX2TX_BIT];
   assign ctrl_tx2rx = s.ctrl[`CTL_TX2RX_BIT];
   assign ctrl_irq = s.ctrl[`CTL_IRQ_BIT];

   // --------------------
   // reset image: power-on lands in off with por noted
   // --------------------
   always_comb
   begin
      reset_s = '0;
      reset_s.st = radio_pkg::off_state; // R18
      reset_s.awake = 1'b1;
      reset_s.por = 1'b1; // R18
      reset_s.mem_clear = 1'b1; // R18
      reset_s.gp_oe_n = 4'hF;
   end

   // --------------------
   // next state
   // --------------------
   always_comb
   begin
      next_s = s;
      next_s.cal = 1'b0;
      next_s.cfg_apply = 1'b0;
      next_s.irq = 1'b0;
      next_s.fw_ack = 3'h0;
      next_s.mem_clear = 1'b0;
      accept = lk.cmd_valid && !lk.cs_n && s.st != radio_pkg::sleep_state;
      writable = s.st == radio_pkg::off_state ||
         s.st == radio_pkg::on_state; // R7

      // wake from sleep
      if (s.st == radio_pkg::sleep_state)
      begin
         if (!lk.cs_n)
         begin
            next_s.st = radio_pkg::off_state; // R3
            next_s.cmd_ready = 1'b0;
            // only the deep variant lost its contents
            if (s.sleep_mode == `SLEEP_DEEP2)
            begin
               next_s.por = 1'b1; // R20
               next_s.mem_clear = 1'b1; // R20
            end
            // timed sleep kept the retained memory: no por
         end
         else if (wake_expire && s.sleep_mode != `SLEEP_DEEP2)
         begin
            next_s.st = radio_pkg::off_state; // R3
            next_s.cmd_ready = 1'b0;
         end
      end

      if (accept)
      begin
         // unlisted code or wrong state leaves all as is
         case (lk.cmd_code) // R23
            `CMD_SLEEP:
               if (writable)
               begin
                  next_s.st = radio_pkg::sleep_state; // R2
                  next_s.sleep_mode = `SLEEP_TIMED;
               end
            `HARDWARE_RESET_COMMAND:
            begin
               next_s.st = radio_pkg::sleep_state; // R5
               next_s.sleep_mode = `SLEEP_DEEP2; // R5
               next_s.pa_en = 1'b0; // R20
               next_s.chan = 24'h000000; // R5
               next_s.ctrl = 8'h00; // R5
            end
            `CMD_ON:
               if (s.st == radio_pkg::off_state)
               begin
                  next_s.st = radio_pkg::on_state;
                  next_s.cal = ctrl_cal; // R9
               end
               else if (s.st == radio_pkg::transmit_state ||
                  s.st == radio_pkg::receive_state)
               begin
                  next_s.st = radio_pkg::on_state; // R13
                  next_s.pa_en = 1'b0;
               end
            `CMD_OFF:
               if (s.st == radio_pkg::on_state)
                  next_s.st = radio_pkg::off_state;
            `CMD_TX:
               if (s.st != radio_pkg::off_state)
               begin
                  next_s.st = radio_pkg::transmit_state;
                  next_s.chan_applied = s.chan; // R22
                  next_s.pa_en = 1'b1;
               end
            `CMD_RX:
               if (s.st != radio_pkg::off_state)
               begin
                  next_s.st = radio_pkg::receive_state;
                  next_s.chan_applied = s.chan; // R22
                  next_s.pa_en = 1'b0;
               end
            `CMD_CONFIG:
               if (writable)
               begin
                  next_s.cfg_apply = 1'b1; // R22
                  next_s.por = 1'b0;
               end
            `CMD_SYNC:
               next_s.cmd_ready = 1'b1;
            `CMD_AES:
               next_s.fw_ack[0] = fw_loaded[0]; // R17
            `CMD_IMGCAL:
               next_s.fw_ack[1] = fw_loaded[1]; // R17
            `CMD_RS:
               next_s.fw_ack[2] = fw_loaded[2]; // R17
            default:
               next_s.st = s.st;
         endcase
      end
      else if (!sport_mode) // R15
      begin
         // an explicit command in the same cycle takes priority
         if (s.st == radio_pkg::transmit_state && packet_sent)
         begin
            next_s.pa_en = 1'b0; // R11
            next_s.irq = ctrl_irq; // R11
            next_s.st = ctrl_tx2rx ? radio_pkg::receive_state :
               radio_pkg::on_state; // R16
         end
         else if (s.st == radio_pkg::receive_state && packet_received)
         begin
            next_s.irq = ctrl_irq; // R14
            next_s.pa_en = ctrl_rx2tx; // R16
            next_s.st = ctrl_rx2tx ? radio_pkg::transmit_state :
               radio_pkg::on_state; // R14
         end
      end

      // memory writes; sleep and radio-active states refuse them
      if (lk.mem_valid && !lk.cs_n && writable) // R7
      begin
         case (lk.mem_addr)
            `ADDR_CHAN_HI: next_s.chan[23:16] = lk.mem_data; // R10
            `ADDR_CHAN_MID: next_s.chan[15:8] = lk.mem_data; // R10
            `ADDR_CHAN_LO: next_s.chan[7:0] = lk.mem_data; // R10
            `ADDR_OPCTRL: next_s.ctrl = lk.mem_data;
            default: next_s.ctrl = next_s.ctrl;
         endcase
      end

      next_s.awake = next_s.st != radio_pkg::sleep_state;
      next_s.tx_serial = next_s.st == radio_pkg::transmit_state &&
         sport_mode && gp_in[`GP_SERIAL_PIN]; // R12

      // pins: only the interrupt pin is ever driven
      for (int i = 0; i < GP_COUNT; i++)
      begin
         next_s.gp_oe_n[i] = (i != `GP_IRQ_PIN); // R6
         next_s.gp_out[i] = (i == `GP_IRQ_PIN) && next_s.awake &&
            next_s.irq; // R6
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= reset_s;
      else
         s <= next_s;
   end

   // --------------------
   // outputs, all straight from the state register
   // --------------------
   assign lk.awake = s.awake;
   assign lk.cmd_ready = s.cmd_ready;
   assign lk.por = s.por;
   assign lk.state = s.st; // R1
   assign state = s.st;
   assign gp_out = s.gp_out;
   assign gp_oe_n = s.gp_oe_n;
   assign pa_enable = s.pa_en;
   assign filter_cal = s.cal;
   assign config_apply = s.cfg_apply;
   assign applied_channel = s.chan_applied;
   assign operating_control = s.ctrl;
   assign tx_serial = s.tx_serial;
   assign packet_irq = s.irq;
   assign fw_cmd_ack = s.fw_ack;
   assign memory_clear = s.mem_clear;

endmodule

// ===== src/radio_host.sv
// host end: AXI4-Lite command registers driving the radio link
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_host #(
   parameter int RESET_WAIT_CYCLES = `HW_RESET_WAIT_US * `CLK_MHZ
) (
   input wire logic aclk, // 200 MHz clock
   input wire logic aresetn, // synchronous reset, low
   radio_link_if.host lk, // link to device
   input wire logic [3:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte strobes, ignored
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [3:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready // read data ready
);

   localparam int WAIT_W = $clog2(RESET_WAIT_CYCLES + 1);

   initial
   begin
      if (RESET_WAIT_CYCLES < 1)
         $error("RESET_WAIT_CYCLES must be at least 1");
   end

   typedef struct packed {
      logic awready;
      logic wready;
      logic arready;
      logic aw_got;
      logic w_got;
      logic [3:0] waddr;
      logic [31:0] wd;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [1:0] ctrl;
      logic pend_cmd;
      logic [7:0] cmd_code;
      logic pend_mem;
      logic [11:0] mem_addr;
      logic [7:0] mem_data;
      logic cmd_valid;
      logic mem_valid;
      logic cs_n;
      logic [WAIT_W-1:0] wait_cnt;
      logic [6:0] cfg_count;
      logic refused;
   } host_state_t;

   host_state_t s;
   host_state_t next_s;
   logic [7:0] code;
   logic bad;
   logic issue_cmd;
   logic cfg_ok;

   always_comb
   begin
      next_s = s;
      code = s.wd[7:0];
      bad = 1'b0;
      next_s.cmd_valid = 1'b0;
      next_s.mem_valid = 1'b0;
      cfg_ok = !lk.por || s.cfg_count == `CFG_BYTES; // R8
      issue_cmd = s.pend_cmd && lk.awake && !s.cs_n &&
         s.wait_cnt == '0;

      // --------------------
      // AXI write: address and data in either order
      // --------------------
      if (awvalid && s.awready)
      begin
         next_s.aw_got = 1'b1;
         next_s.waddr = awaddr;
      end
      if (wvalid && s.wready)
      begin
         next_s.w_got = 1'b1;
         next_s.wd = wdata;
      end
      if (s.bvalid && bready)
         next_s.bvalid = 1'b0;
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = `RESP_OKAY;
         case (s.waddr)
            `REG_CTRL:
               next_s.ctrl = s.wd[1:0];
            `REG_CMD:
            begin
               bad = s.pend_cmd;
               if (!lk.cmd_ready && code != `CMD_SYNC &&
                  code != `HARDWARE_RESET_COMMAND)
                  bad = 1'b1; // R19
               if (code == `CMD_SLEEP && !s.ctrl[`CTRL_WAKE_BIT])
                  bad = 1'b1; // R4
               if (code == `CMD_ON && lk.state == radio_pkg::off_state &&
                  !cfg_ok)
                  bad = 1'b1; // R8
               next_s.refused = bad;
               next_s.pend_cmd = s.pend_cmd || !bad;
               if (!bad)
                  next_s.cmd_code = code;
            end
            `REG_MEM:
               if (s.pend_mem)
                  next_s.refused = 1'b1;
               else
               begin
                  next_s.pend_mem = 1'b1;
                  next_s.mem_addr = s.wd[`MEM_ADDR_LSB+11:`MEM_ADDR_LSB];
                  next_s.mem_data = s.wd[7:0];
               end
            default:
               next_s.bresp = `RESP_DECERR;
         endcase
      end

      // --------------------
      // AXI read: answer one cycle after the address
      // --------------------
      if (s.rvalid && rready)
         next_s.rvalid = 1'b0;
      if (arvalid && s.arready)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp = `RESP_OKAY;
         next_s.rdata = 32'h00000000;
         case (araddr)
            `REG_CTRL: next_s.rdata[1:0] = s.ctrl;
            `REG_STATUS:
               next_s.rdata[7:0] = {s.refused, s.pend_cmd || s.pend_mem,
                  lk.por, lk.awake, lk.cmd_ready, lk.state};
            default: next_s.rresp = `RESP_DECERR;
         endcase
      end

      // --------------------
      // link side: command first, then one memory byte
      // --------------------
      if (s.wait_cnt != '0)
         next_s.wait_cnt = s.wait_cnt - 1'b1; // R20
      if (issue_cmd)
      begin
         next_s.pend_cmd = 1'b0;
         next_s.cmd_valid = 1'b1; // R1
         if (s.cmd_code == `HARDWARE_RESET_COMMAND)
         begin
            next_s.wait_cnt = WAIT_W'(RESET_WAIT_CYCLES); // R20
            next_s.cfg_count = 7'h00; // R20
         end
      end
      else if (s.pend_mem && lk.awake && !s.cs_n && s.wait_cnt == '0)
      begin
         next_s.pend_mem = 1'b0;
         next_s.mem_valid = 1'b1;
         if (s.mem_addr >= `CFG_BASE && s.mem_addr <= `CFG_LAST &&
            s.cfg_count != `CFG_BYTES)
            next_s.cfg_count = s.cfg_count + 7'h01; // R19
      end

      // rises right after a strobe unless the CS bit is set, else a sleep command would self-wake
      next_s.cs_n = !((s.ctrl[`CTRL_CS_BIT] || s.pend_cmd ||
         s.pend_mem) && s.wait_cnt == '0); // R21

      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.cs_n <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign arready = s.arready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;
   assign lk.cs_n = s.cs_n;
   assign lk.cmd_valid = s.cmd_valid;
   assign lk.cmd_code = s.cmd_code;
   assign lk.mem_valid = s.mem_valid;
   assign lk.mem_addr = s.mem_addr;
   assign lk.mem_data = s.mem_data;

endmodule

// ===== verif/radio_state_controller_monitor.sv
// assertion checker watching the radio control link
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_state_controller_monitor (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low
   input wire logic cs_n, // chip select, low
   input wire logic cmd_valid, // command strobe
   input wire logic [7:0] cmd_code, // command byte
   input wire logic awake, // device awake
   input wire logic cmd_ready, // command ready
   input wire logic por, // power-on reset seen
   input radio_pkg::radio_state_t state // device state
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // --------------------
   // helpers
   // --------------------
   logic deep;
   // set by hw reset, so a later wake must report power-on reset
   always_ff @(posedge aclk)
      if (!aresetn)
         deep <= 1'b0;
      else if (cmd_valid && !cs_n && cmd_code == `HARDWARE_RESET_COMMAND)
         deep <= 1'b1;
      else if (state != radio_pkg::sleep_state)
         deep <= 1'b0;
   sequence taken(logic [7:0] c);
      cmd_valid && !cs_n && cmd_code == c;
   endsequence
   sequence cs_wake;
      state == radio_pkg::sleep_state && !cs_n;
   endsequence
   // --------------------
   // properties
   // --------------------
   a_sleep_entry: assert property ((state inside {radio_pkg::off_state,
      radio_pkg::on_state}) ##0 taken(`CMD_SLEEP)
      |=> state == radio_pkg::sleep_state) else $error("sleep not entered");
   a_sleep_ignored: assert property ((state inside
      {radio_pkg::transmit_state, radio_pkg::receive_state})
      ##0 taken(`CMD_SLEEP) |=> state != radio_pkg::sleep_state)
      else $error("sleep taken from tx or rx");
   a_cs_wake: assert property (cs_wake
      |=> state == radio_pkg::off_state && !cmd_ready)
      else $error("chip select wake wrong");
   a_deep_por: assert property (deep ##0 cs_wake |=> por)
      else $error("no por after hw reset wake");
   a_warm_wake: assert property ((!deep && !por) ##0 cs_wake |=> !por)
      else $error("por on warm wake");
   a_hw_reset: assert property ((state != radio_pkg::sleep_state)
      ##0 taken(`HARDWARE_RESET_COMMAND) |=> (state == radio_pkg::sleep_state)[*8])
      else $error("hw reset left sleep early");
   a_awake_level: assert property (awake ==
      (state != radio_pkg::sleep_state)) else $error("awake mismatch");
   a_on_entry: assert property ((state inside {radio_pkg::off_state,
      radio_pkg::transmit_state, radio_pkg::receive_state})
      ##0 taken(`CMD_ON) |=> state == radio_pkg::on_state)
      else $error("on not entered");
   a_strobe_cs: assert property ($rose(cmd_valid)
      |-> !cs_n && $past(cs_n) == 1'b0) else $error("strobe without cs");
   a_reset_off: assert property ($rose(aresetn)
      |-> state == radio_pkg::off_state && por && awake)
      else $error("bad state after reset");
endmodule

// ===== verif/radio_state_controller_bench.sv
// self-checking bench for the radio controller and its host
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_state_controller_bench;
   logic aclk, aresetn, sport, pa, cal, irq, txs, cfgp, mclr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [2:0] ev, fwl, fwa, fw_seen;
   logic [3:0] gp_in, gp_out, gp_oe_n, awaddr, araddr, wstrb;
   logic [23:0] chan, achan;
   logic [7:0] opctl;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   radio_pkg::radio_state_t state;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int mismatches = 0, check_count = 0, cal_n = 0, irq_n = 0, n;
   int cfg_n = 0, mc_n = 0;
   radio_link_if lk ();
   radio_state_controller u_radio_state_controller (.aclk(aclk),
      .aresetn(aresetn), .lk(lk), .wake_expire(ev[2]), .packet_sent(ev[1]),
      .packet_received(ev[0]), .sport_mode(sport), .fw_loaded(fwl),
      .gp_in(gp_in), .gp_out(gp_out), .gp_oe_n(gp_oe_n), .state(state),
      .pa_enable(pa), .filter_cal(cal), .config_apply(cfgp),
      .applied_channel(achan), .operating_control(opctl), .tx_serial(txs),
      .packet_irq(irq), .fw_cmd_ack(fwa), .memory_clear(mclr));
   radio_host #(.RESET_WAIT_CYCLES(20)) u_radio_host (.aclk(aclk),
      .aresetn(aresetn), .lk(lk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));
   radio_state_controller_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
      .cs_n(lk.cs_n), .cmd_valid(lk.cmd_valid), .cmd_code(lk.cmd_code),
      .awake(lk.awake), .cmd_ready(lk.cmd_ready), .por(lk.por),
      .state(lk.state));
   // --------------------
   // tasks
   // --------------------
   task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // raises both channels together, drops each when taken
   task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] r);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (bvalid !== 1'b1);
      // lets the link strobe land before the next request
      repeat (6) @(posedge aclk);
   endtask
   task automatic rd(logic [3:0] a, logic [33:0] e);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
   endtask
   task automatic cmd(logic [7:0] c);
      wr(`REG_CMD, {24'h0, c}, `RESP_OKAY);
   endtask
   task automatic st(logic [7:0] e);
      rd(`REG_STATUS, {26'h0, e});
   endtask
   task automatic mem(logic [11:0] a, logic [7:0] d);
      wr(`REG_MEM, {4'h0, a, 8'h00, d}, `RESP_OKAY);
   endtask
   task automatic pulse(int b);
      ev[b] <= 1'b1;
      @(posedge aclk);
      ev <= 3'h0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic sx(radio_pkg::radio_state_t e);
      check("state", state, e);
   endtask
   // --------------------
   // clock, compare process, watchdog, tests
   // --------------------
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cal_n <= cal_n + cal;
      irq_n <= irq_n + irq;
      cfg_n <= cfg_n + cfgp;
      mc_n <= mc_n + mclr;
      fw_seen <= fw_seen | fwa;
      if (bvalid && bready) check("bresp", bresp, bq.pop_front());
      if (rvalid && rready) check("read", {rresp, rdata}, rq.pop_front());
   end
   initial
   begin
      #100000;
      mismatches++;
      report_and_stop();
   end
   initial
   begin
      aresetn = 1'b0;
      {ev, sport, fwl, gp_in, fw_seen, awvalid, wvalid, arvalid} = '0;
      {awaddr, araddr, wdata} = '0;
      {bready, rready, wstrb} = 6'h3F;
      void'($urandom(44452));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      st(8'h31);
      check("oe", gp_oe_n, 4'h7);
      rd(`REG_CMD, {`RESP_DECERR, 32'h0});
      wr(`REG_CTRL, 32'h2, `RESP_OKAY);
      rd(`REG_CTRL, {2'b00, 32'h2});
      cmd(`CMD_ON);
      st(8'hB1);
      cmd(`CMD_SYNC);
      cmd(`CMD_ON);
      st(8'hB9);
      chan = 24'($urandom);
      for (int i = 0; i < 64; i++) mem(`CFG_BASE + 12'(i), 8'($urandom));
      mem(`ADDR_CHAN_HI, chan[23:16]);
      mem(`ADDR_CHAN_MID, chan[15:8]);
      mem(`ADDR_CHAN_LO, chan[7:0]);
      mem(`ADDR_OPCTRL, 8'h09);
      cmd(`CMD_CONFIG);
      st(8'h19);
      check("cfg", cfg_n, 1);
      n = cal_n;
      cmd(`CMD_ON);
      check("cal", cal_n - n, 1);
      check("ctl", opctl, 8'h09);
      $display("test init done");
      cmd(`CMD_TX);
      check("pa", pa, 1'b1);
      check("chan", achan, chan);
      n = irq_n;
      pulse(1);
      sx(radio_pkg::on_state);
      check("irq", {pa, 8'(irq_n - n)}, 9'h001);
      cmd(`CMD_RX);
      pulse(0);
      sx(radio_pkg::on_state);
      mem(`ADDR_OPCTRL, 8'h06);
      cmd(`CMD_TX);
      pulse(1);
      sx(radio_pkg::receive_state);
      pulse(0);
      sx(radio_pkg::transmit_state);
      cmd(`CMD_ON);
      $display("test frames done");
      sport <= 1'b1;
      cmd(`CMD_TX);
      pulse(1);
      sx(radio_pkg::transmit_state);
      gp_in <= 4'($urandom);
      repeat (2) @(posedge aclk);
      check("ser", txs, gp_in[1]);
      cmd(`CMD_SLEEP);
      sx(radio_pkg::transmit_state);
      cmd(`CMD_ON);
      cmd(`CMD_RX);
      pulse(0);
      sx(radio_pkg::receive_state);
      cmd(`CMD_ON);
      sx(radio_pkg::on_state);
      sport <= 1'b0;
      cmd(`CMD_OFF);
      cmd(`CMD_TX);
      sx(radio_pkg::off_state);
      fwl <= 3'($urandom);
      cmd(`CMD_ON);
      cmd(`CMD_AES);
      cmd(`CMD_IMGCAL);
      cmd(`CMD_RS);
      check("fw", fw_seen, fwl);
      $display("test sport done");
      cmd(`CMD_SLEEP);
      sx(radio_pkg::sleep_state);
      check("gp", {gp_out[3], gp_oe_n}, 5'h07);
      pulse(2);
      st(8'h11);
      cmd(`CMD_SYNC);
      cmd(`CMD_SLEEP);
      wr(`REG_CTRL, 32'h3, `RESP_OKAY);
      st(8'h11);
      wr(`REG_CTRL, 32'h2, `RESP_OKAY);
      cmd(`HARDWARE_RESET_COMMAND);
      pulse(2);
      sx(radio_pkg::sleep_state);
      n = mc_n;
      wr(`REG_CTRL, 32'h3, `RESP_OKAY);
      repeat (30) @(posedge aclk);
      st(8'h31);
      check("mclr", mc_n - n, 1);
      check("ctl", opctl, 8'h00);
      $display("test sleep done");
      report_and_stop();
   end
endmodule
